// [hw/eeprom_array_mem.sv]
// eeprom storage with ecc check bits and registered read data
`timescale 1ns/1ps
`include "eeprom_fe_defines.svh"
module eeprom_array_mem (
  // clock
  input  wire logic        clk_i,
  // write port
  input  wire logic        we_i,
  input  wire logic        id_page_i,
  input  wire logic [12:0] waddr_i,
  input  wire logic [7:0]  wdata_i,
  // read port
  input  wire logic        rid_page_i,
  input  wire logic [12:0] raddr_i,
  output logic      [7:0]  rdata_o
);
  logic [12:0] main_mem [0:8191];
  logic [12:0] id_mem   [0:31];
  logic [12:0] word_w;
  logic [12:0] word_r;
  logic [7:0]  rdata_r;

  // hamming style check bits over the data byte
  function automatic logic [12:0] enc(input logic [7:0] d);
    logic [4:0] p;
    p[0] = ^(d & 8'h5_B);
    p[1] = ^(d & 8'h6_D);
    p[2] = ^(d & 8'h8_E);
    p[3] = ^(d & 8'hF_0);
    p[4] = ^d ^ (^p[3:0]);
    return {p, d};
  endfunction : enc

  // correct a single bit error in the data bits
  function automatic logic [7:0] dec(input logic [12:0] w);
    logic [3:0]  s;
    logic [7:0]  d;
    logic [12:0] e;
    d = w[7:0];
    e = enc(d);
    s = e[11:8] ^ w[11:8];
    for (int i = 0; i < 8; i++) begin
      if (s == {^(8'hF_0 & (8'h0_1 << i)), ^(8'h8_E & (8'h0_1 << i)),
                ^(8'h6_D & (8'h0_1 << i)), ^(8'h5_B & (8'h0_1 << i))} && s != 4'h0_0) begin
        d[i] = ~d[i];
      end
    end
    return d;
  endfunction : dec

  assign word_w = enc(wdata_i);
  assign word_r = rid_page_i ? id_mem[raddr_i[4:0]] : main_mem[raddr_i];

  always_ff @(posedge clk_i) begin
    if (we_i && !id_page_i) begin
      main_mem[waddr_i] <= word_w;
    end
    if (we_i && id_page_i) begin
      id_mem[waddr_i[4:0]] <= word_w;
    end
    rdata_r <= dec(word_r);
  end

  assign rdata_o = rdata_r;
endmodule : eeprom_array_mem

// [hw/eeprom_fe.sv]
// i2c slave front end of a serial eeprom, link on scl domain
// Operation
// - sample sda on every scl rising edge; scl times input and output
// - start is sda falling while scl high; precedes each transfer
// - watch for start always except during internal write cycle
// - stop is sda rising while scl high; ends communication
// - stop after a write launches the write cycle, not earlier
// - device is always slave and never starts transfers
// - sda driven open drain only: pull low or release
// - chip select straps compared with select code bits b3 b2 b1
// - unconnected strap reads as logic zero
// - write protect high inhibits all array writes
// - write protect low or floating permits writes
// - protected: ack select and address, nack every data byte
// - main array is 256 pages of 32 bytes, byte alterable
// - ecc applied automatically, invisible to master
// - extra 32 byte id page, lockable to read only
// - transmitter releases sda after 8 bits; receiver acks on ninth
// - ack select only for type 1010b or 1011b with matching straps
// - select code last bit: 1 read, 0 write
// - two address bytes msb first, each acknowledged
`timescale 1ns/1ps
`include "eeprom_fe_defines.svh"
module eeprom_fe #(
  parameter int WCYC_CYCLES = `WCYC_CYCLES
) (
  // system clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  // i2c pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // straps
  input  wire logic [2:0] chip_select_straps_i,
  input  wire logic       write_protect_input_i,
  // status
  output logic            write_busy_o
);
  // ---------------- link domain (scl) ----------------
  typedef struct packed {
    eeprom_fe_pkg::link_state_t st;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic        ack;
    logic        rd;
    logic        id_page;
    logic        hi_done;
    logic [12:0] addr;
    logic        wr_seen;
    logic        locked;
    logic        lock_req;
    eeprom_fe_pkg::wr_req_t wq;
    logic [7:0]  txd;
  } link_t;

  link_t lk_r;
  link_t lk_nxt;
  logic  start_tgl_r;
  logic  stop_tgl_r;
  logic  sda_lo_r;
  logic  busy_l1_r;
  logic  busy_l2_r;
  logic  start_seen_r;
  logic  start_ack_r;
  logic  stop_ack_r;
  logic  rst_link_n;
  logic  rst_busy_n;
  logic  wbusy_r;
  logic [7:0] rdata;

  // start detect: sda falls with scl high
  always_ff @(negedge sda_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_tgl_r <= 1'b0;
    end else if (scl_i && !busy_l2_r) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  // stop detect: sda rises with scl high
  always_ff @(posedge sda_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stop_tgl_r <= 1'b0;
    end else if (scl_i) begin
      stop_tgl_r <= ~stop_tgl_r;
    end
  end

  assign rst_link_n = arst_n_i;
  // busy sync cleared at once when the write cycle ends; scl may be idle then
  assign rst_busy_n = arst_n_i & wbusy_r;

  // busy level into scl domain
  always_ff @(posedge scl_i or negedge rst_busy_n) begin
    if (!rst_busy_n) begin
      busy_l1_r <= 1'b0;
      busy_l2_r <= 1'b0;
    end else begin
      busy_l1_r <= wbusy_r;
      busy_l2_r <= busy_l1_r;
    end
  end

  logic start_pend;
  logic stop_pend;
  assign start_pend = start_tgl_r != start_ack_r;
  assign stop_pend  = stop_tgl_r != stop_ack_r;

  // link fsm, clocked by scl rising edge
  always_comb begin
    lk_nxt = lk_r;
    if (stop_pend) begin
      lk_nxt.st      = eeprom_fe_pkg::ST_IDLE;
      lk_nxt.ack     = 1'b0;
      lk_nxt.wr_seen = 1'b0; // launch already taken by system side
    end
    if (start_pend && !busy_l2_r) begin
      lk_nxt.st    = eeprom_fe_pkg::ST_SEL;
      lk_nxt.bitn  = 4'h0_1;
      lk_nxt.shreg = {7'h0_0, sda_i};
      lk_nxt.ack   = 1'b0;
    end else if (busy_l2_r || stop_pend) begin
      lk_nxt.st  = eeprom_fe_pkg::ST_IDLE;
      lk_nxt.ack = 1'b0;
    end else if (lk_r.st != eeprom_fe_pkg::ST_IDLE) begin
      if (lk_r.bitn == 4'h0_8) begin // ninth clock
        lk_nxt.bitn = 4'h0_0;
        lk_nxt.ack  = 1'b0;
        if (lk_r.st == eeprom_fe_pkg::ST_READ) begin
          if (sda_i) begin
            lk_nxt.st = eeprom_fe_pkg::ST_IDLE;
          end
          lk_nxt.addr = lk_r.addr + 13'h0_001;
          lk_nxt.txd  = rdata;
        end
      end else begin
        lk_nxt.bitn  = lk_r.bitn + 4'h0_1;
        lk_nxt.shreg = {lk_r.shreg[6:0], sda_i};
        lk_nxt.txd   = {lk_r.txd[6:0], 1'b1};
        if (lk_r.bitn == 4'h0_7) begin
          unique case (lk_r.st)
            eeprom_fe_pkg::ST_SEL: begin
              // type and strap match
              if ((lk_r.shreg[6:3] == `TYPE_ARRAY || lk_r.shreg[6:3] == `TYPE_IDPAGE)
                  && lk_r.shreg[2:0] == chip_select_straps_i) begin
                lk_nxt.ack     = 1'b1;
                lk_nxt.id_page = lk_r.shreg[3];
                lk_nxt.rd      = sda_i;
                lk_nxt.hi_done = 1'b0;
                lk_nxt.st = sda_i ? eeprom_fe_pkg::ST_READ : eeprom_fe_pkg::ST_ADDR;
                lk_nxt.txd = rdata;
              end else begin
                lk_nxt.st = eeprom_fe_pkg::ST_IDLE;
              end
            end
            eeprom_fe_pkg::ST_ADDR: begin
              lk_nxt.ack = 1'b1;
              if (!lk_r.hi_done) begin
                lk_nxt.addr[12:8] = {lk_r.shreg[3:0], sda_i};
                lk_nxt.hi_done    = 1'b1;
                lk_nxt.lock_req   = lk_r.id_page && lk_r.shreg[1];
              end else begin
                lk_nxt.addr[7:0] = {lk_r.shreg[6:0], sda_i};
                lk_nxt.st        = eeprom_fe_pkg::ST_DATA;
              end
            end
            eeprom_fe_pkg::ST_DATA: begin
              // protected or locked page: no ack, no write
              if (!write_protect_input_i && !(lk_r.id_page && lk_r.locked)) begin
                lk_nxt.ack = 1'b1;
                if (lk_r.lock_req) begin
                  lk_nxt.locked = 1'b1;
                end else begin
                  lk_nxt.wq.valid   = 1'b1;
                  lk_nxt.wq.id_page = lk_r.id_page;
                  lk_nxt.wq.addr    = lk_r.addr; // byte alterable
                  lk_nxt.wq.data    = {lk_r.shreg[6:0], sda_i};
                  lk_nxt.wr_seen    = 1'b1;
                end
                lk_nxt.addr[4:0] = lk_r.addr[4:0] + 5'h0_1; // page wrap
              end
            end
            default: begin
              lk_nxt.ack = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge scl_i or negedge rst_link_n) begin
    if (!rst_link_n) begin
      lk_r    <= '0;
      lk_r.st <= eeprom_fe_pkg::ST_IDLE;
      start_ack_r <= 1'b0;
      stop_ack_r  <= 1'b0;
    end else begin
      lk_r        <= lk_nxt;
      start_ack_r <= start_tgl_r;
      stop_ack_r  <= stop_tgl_r;
    end
  end

  // sda changes only with scl low; open drain
  always_ff @(negedge scl_i or negedge rst_link_n) begin
    if (!rst_link_n) begin
      sda_lo_r <= 1'b0;
    end else begin
      sda_lo_r <= lk_r.ack ||
                  (lk_r.st == eeprom_fe_pkg::ST_READ && lk_r.bitn != 4'h0_8 && !lk_r.txd[7]);
    end
  end

  // ---------------- system domain ----------------
  typedef struct packed {
    logic [2:0]  tg_sync;
    logic [1:0]  wr_sync;
    logic        busy;
    logic [31:0] cnt;
    logic        out_oe;
  } sys_t;

  sys_t sy_r;
  sys_t sy_nxt;
  logic [1:0] oe_sync_r;
  logic       wr_launch;

  // stop edge seen while a written byte is pending
  assign wr_launch = (sy_r.tg_sync[2] != sy_r.tg_sync[1]) && sy_r.wr_sync[1];

  always_comb begin
    sy_nxt         = sy_r;
    sy_nxt.tg_sync = {sy_r.tg_sync[1:0], stop_tgl_r};
    sy_nxt.wr_sync = {sy_r.wr_sync[0], lk_r.wr_seen};
    sy_nxt.out_oe  = oe_sync_r[1];
    if (wr_launch) begin
      sy_nxt.busy = 1'b1;
      sy_nxt.cnt  = 32'(WCYC_CYCLES);
    end else if (sy_r.busy) begin
      if (sy_r.cnt <= 32'h0000_0001) begin
        sy_nxt.busy = 1'b0;
      end
      sy_nxt.cnt = sy_r.cnt - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sy_r      <= '0;
      oe_sync_r <= 2'h0;
    end else begin
      sy_r      <= sy_nxt;
      oe_sync_r <= {oe_sync_r[0], sda_lo_r};
    end
  end

  assign wbusy_r      = sy_r.busy;
  assign write_busy_o = sy_r.busy;
  assign sda_oe_o     = sda_lo_r;
  assign sda_o        = 1'b0; // never drives high

  // storage with ecc, written from the last latched byte
  eeprom_array_mem u_mem (
    .clk_i      (scl_i),
    .we_i       (lk_r.wq.valid && lk_r.wr_seen && lk_nxt.st == eeprom_fe_pkg::ST_DATA),
    .id_page_i  (lk_r.wq.id_page),
    .waddr_i    (lk_r.wq.addr),
    .wdata_i    (lk_r.wq.data),
    .rid_page_i (lk_r.id_page),
    .raddr_i    (lk_r.addr),
    .rdata_o    (rdata)
  );

  // assertions on the link and system domains
  property p_oe_low_only;
    @(posedge clk_sys_i) disable iff (!arst_n_i) sda_oe_o |-> (sda_o == 1'b0);
  endproperty
  a_oe_low_only: assert property (p_oe_low_only) else $error("sda driven high");

  sequence s_wr_launch;
    wr_launch;
  endsequence
  property p_busy_on_stop;
    @(posedge clk_sys_i) disable iff (!arst_n_i) s_wr_launch |=> write_busy_o;
  endproperty
  a_busy_on_stop: assert property (p_busy_on_stop) else $error("write cycle not started");

  property p_busy_holds;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (write_busy_o && sy_r.cnt > 32'h0000_0002 && !wr_launch) |=> write_busy_o;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("write cycle ended early");

  property p_idle_when_busy;
    @(posedge scl_i) disable iff (!arst_n_i) busy_l2_r |=> lk_r.st == eeprom_fe_pkg::ST_IDLE;
  endproperty
  a_idle_when_busy: assert property (p_idle_when_busy) else $error("bus not ignored");

  property p_no_wp_write;
    @(posedge scl_i) disable iff (!arst_n_i)
      (write_protect_input_i && lk_r.st == eeprom_fe_pkg::ST_DATA) |=> !$rose(lk_r.wr_seen);
  endproperty
  a_no_wp_write: assert property (p_no_wp_write) else $error("write while protected");

  property p_sel_nack_bad;
    @(posedge scl_i) disable iff (!arst_n_i)
      (lk_r.st == eeprom_fe_pkg::ST_SEL && lk_r.bitn == 4'h0_7 && !stop_pend && !start_pend
       && lk_r.shreg[2:0] != chip_select_straps_i) |=> !lk_r.ack;
  endproperty
  a_sel_nack_bad: assert property (p_sel_nack_bad) else $error("wrong select acked");

  property p_addr_ack;
    @(posedge scl_i) disable iff (!arst_n_i)
      (lk_r.st == eeprom_fe_pkg::ST_ADDR && lk_r.bitn == 4'h0_7 && !stop_pend && !start_pend
       && !busy_l2_r) |=> lk_r.ack;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address byte not acked");

  property p_start_resets;
    @(posedge scl_i) disable iff (!arst_n_i)
      (start_pend && !stop_pend && !busy_l2_r) |=> (lk_r.st == eeprom_fe_pkg::ST_SEL
                                                   && lk_r.bitn == 4'h0_1);
  endproperty
  a_start_resets: assert property (p_start_resets) else $error("start not restarting");
endmodule : eeprom_fe

// [hw/eeprom_fe_defines.svh]
// constants of the serial eeprom front end
`ifndef EEPROM_FE_DEFINES_SVH
`define EEPROM_FE_DEFINES_SVH
`define TYPE_ARRAY        4'h0_00A
`define TYPE_IDPAGE       4'h0_00B
`define PAGE_COUNT        9'h0_100
`define PAGE_BYTES        6'h0_20
`define ARRAY_BYTES       14'h0_2000
`define ADDR_BITS         13
`define ECC_BITS          5
`define WCYC_TIME_NS      4000000
`define CLK_PERIOD_NS     8
`define WCYC_CYCLES       (`WCYC_TIME_NS / `CLK_PERIOD_NS)
`define CODEWORD_BITS     13
`endif

// [hw/eeprom_fe_pkg.sv]
// types of the serial eeprom front end
package eeprom_fe_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h0_01,
    ST_SEL  = 5'h0_02,
    ST_ADDR = 5'h0_04,
    ST_DATA = 5'h0_08,
    ST_READ = 5'h0_10
  } link_state_t;

  typedef struct packed {
    logic        valid;
    logic        id_page;
    logic [12:0] addr;
    logic [7:0]  data;
  } wr_req_t;
endpackage : eeprom_fe_pkg

// [test/i2c_eeprom_bus_front_end_tb.sv]
// self-checking bench of the serial eeprom front end
`timescale 1ns/1ps
module i2c_eeprom_bus_front_end_tb;
  localparam int WCYC = 400;
  logic       clk_sys    = 1'b0;
  logic       arst_n     = 1'b0;
  logic [2:0] straps     = 3'h0;
  logic       wp         = 1'b0;
  logic       scl;
  logic       sda_m;
  logic       sda_dv;
  logic       sda_oe;
  logic       busy;
  wire        sda_w      = sda_m & ~(sda_oe & ~sda_dv);
  int         num_errors = 0;
  int         compares   = 0;
  int         cyc        = 0;
  int         busy_len   = 0;

  always #4 clk_sys = ~clk_sys;

  i2c_master_model u_mst (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));

  eeprom_fe #(.WCYC_CYCLES(WCYC)) u_dut (
    .clk_sys_i(clk_sys), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_dv), .sda_oe_o(sda_oe), .chip_select_straps_i(straps),
    .write_protect_input_i(wp), .write_busy_o(busy)
  );

  // open drain: driven value must be low whenever enabled
  always @(negedge scl) begin
    if (sda_oe === 1'b1 && sda_dv !== 1'b0) begin
      num_errors++;
      $display("unexpected sda_o: expected 0 seen %b", sda_dv);
    end
  end

  always @(negedge clk_sys) begin
    cyc++;
    if (busy === 1'b1) busy_len++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one byte with its expected acknowledge
  task automatic xfer(input logic [7:0] b, input logic exp_nack, input string what);
    logic a;
    u_mst.wr_byte(b, a);
    check(what, {7'h00, a}, {7'h00, exp_nack});
  endtask : xfer

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    check("write_busy", {7'h00, busy}, {7'h00, lvl});
  endtask : wait_busy

  // select type and strap matching
  task automatic sel_table();
    logic [7:0] sels [4];
    logic       nk;
    sels = '{8'hA4, 8'hAA, 8'hC4, 8'hB4};
    @(negedge clk_sys) straps = 3'h2;
    for (int i = 0; i < 4; i++) begin
      nk = !((sels[i][7:4] == 4'hA || sels[i][7:4] == 4'hB) && sels[i][3:1] == 3'h2);
      u_mst.start();
      xfer(sels[i], nk, "select ack");
      u_mst.stop();
    end
    check("no write on empty stop", {7'h00, busy}, 8'h00);
    @(negedge clk_sys) straps = 3'h0;
  endtask : sel_table

  // byte write, bus ignored during the write cycle
  task automatic write_ok(input logic [7:0] d);
    u_mst.start();
    xfer(8'hA0, 1'b0, "select ack");
    xfer(8'h0A, 1'b0, "addr hi ack");
    xfer(8'h5C, 1'b0, "addr lo ack");
    xfer(d, 1'b0, "data ack");
    check("busy before stop", {7'h00, busy}, 8'h00);
    busy_len = 0;
    u_mst.stop();
    wait_busy(1'b1);
    u_mst.start();
    xfer(8'hA0, 1'b1, "select while busy");
    u_mst.stop();
    wait_busy(1'b0);
    check("busy length ok", {7'h00, (busy_len >= WCYC && busy_len <= WCYC + 3)}, 8'h01);
  endtask : write_ok

  // protected write: select and address acked, data refused
  task automatic write_prot();
    @(negedge clk_sys) wp = 1'b1;
    u_mst.start();
    xfer(8'hA0, 1'b0, "wp select ack");
    xfer(8'h0A, 1'b0, "wp addr hi ack");
    xfer(8'h5C, 1'b0, "wp addr lo ack");
    xfer(8'h3C, 1'b1, "wp data nack");
    u_mst.stop();
    repeat (30) @(negedge clk_sys);
    check("wp no write cycle", {7'h00, busy}, 8'h00);
    @(negedge clk_sys) wp = 1'b0;
  endtask : write_prot

  // random read through repeated start
  task automatic read_back(input logic [7:0] exp);
    logic [7:0] d;
    u_mst.start();
    xfer(8'hA0, 1'b0, "rd select w");
    xfer(8'h0A, 1'b0, "rd addr hi");
    xfer(8'h5C, 1'b0, "rd addr lo");
    u_mst.start();
    xfer(8'hA1, 1'b0, "rd select r");
    u_mst.rd_byte(d);
    check("read data", d, exp);
    u_mst.stop();
  endtask : read_back

  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    #200;
    sel_table();
    write_ok(8'hA5);
    read_back(8'hA5);
    write_prot();
    read_back(8'hA5);
    end_sim();
  end
endmodule : i2c_eeprom_bus_front_end_tb

// [test/i2c_master_model.sv]
// i2c bus master model driving scl and open drain sda
`timescale 1ns/1ps
module i2c_master_model (
  // bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // scl idles high between frames, sda released (pull-up)
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // start or repeated start
  task automatic start();
    #3;
    sda_o = 1'b1;
    #20 scl_o = 1'b1;
    #40 sda_o = 1'b0;
    #40 scl_o = 1'b0;
    #20;
  endtask : start

  task automatic stop();
    sda_o = 1'b0;
    #20 scl_o = 1'b1;
    #40 sda_o = 1'b1;
    #40;
  endtask : stop

  // byte msb first, sda changed only while scl low
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      #20 scl_o = 1'b1;
      #40 scl_o = 1'b0;
      #20;
    end
    sda_o = 1'b1;
    #20 scl_o = 1'b1;
    #20 ack = sda_i;
    #20 scl_o = 1'b0;
    #20;
  endtask : wr_byte

  // read one byte then nack it
  task automatic rd_byte(output logic [7:0] b);
    sda_o = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #20 scl_o = 1'b1;
      #20 b[i] = sda_i;
      #20 scl_o = 1'b0;
      #20;
    end
    #20 scl_o = 1'b1;
    #40 scl_o = 1'b0;
    #20;
  endtask : rd_byte
endmodule : i2c_master_model
